//--- hw/gpm_pkg.sv
// Constants, codes and carrier types for the general-pin function multiplexer.
// Operation
// - First-pin select is bits 4:0, resets zero.
// - First-pin code 0x0 gives legacy interrupt level.
// - First-pin code 0x1 gives configured interrupt.
// - First-pin code 0x2 spans first-to-last timeslot.
// - First-pin codes 0x5-0x7 route LED pulse trains.
// - First-pin codes 0xC-0xE flag data cycles.
// - First-pin code 0xF toggles every sample.
// - Second-pin codes 0x05-0x07 route LED pulses.
// - Second-pin codes 0x0C-0x0E flag data cycles.
// - Second-pin code 0x0F toggles every sample.
// - Second-pin 0x10 low, 0x11 high, 0x13 oscillator.
// - Second-pin select is bits 12:8 of 0x0B.
// - First-pin polarity one makes pin active low.
package gpm_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned SEL_W  = 5;

  localparam logic [7:0] ADDR_PIN_CTRL = 8'h02;
  localparam logic [7:0] ADDR_ALT_CFG  = 8'h0b;

  localparam int unsigned POL_BIT  = 0;
  localparam int unsigned SEL0_LSB = 0;
  localparam int unsigned SEL1_LSB = 8;

  localparam logic [4:0] SEL_RESET = 5'h00;
  localparam logic       POL_RESET = 1'h0;

  localparam logic [4:0] CODE_LEGACY = 5'h00;
  localparam logic [4:0] CODE_INT    = 5'h01;
  localparam logic [4:0] CODE_SPAN   = 5'h02;
  localparam logic [4:0] CODE_LED_A  = 5'h05;
  localparam logic [4:0] CODE_LED_B  = 5'h06;
  localparam logic [4:0] CODE_LED_AB = 5'h07;
  localparam logic [4:0] CODE_DCY_A  = 5'h0c;
  localparam logic [4:0] CODE_DCY_B  = 5'h0d;
  localparam logic [4:0] CODE_DCY_AB = 5'h0e;
  localparam logic [4:0] CODE_TOGGLE = 5'h0f;
  localparam logic [4:0] CODE_ZERO   = 5'h10;
  localparam logic [4:0] CODE_ONE    = 5'h11;
  localparam logic [4:0] CODE_OSC    = 5'h13;

  // Signals handed over by the timeslot sequencer and interrupt logic.
  typedef struct packed {
    logic legacy_int;
    logic cfg_int;
    logic legacy_sample_out;
    logic slot_first_start;
    logic slot_last_end;
    logic led_a;
    logic led_b;
    logic data_cycle_a;
    logic data_cycle_b;
    logic sample_tick;
  } gpm_src_t;

  // Levels derived inside the block that both pin selectors read.
  typedef struct packed {
    logic span;
    logic toggle;
    logic osc;
  } gpm_derived_t;

endpackage : gpm_pkg

//--- hw/gpm_sync.sv
// Three-stage synchroniser with agreement filter for an asynchronous level.
`timescale 1ns/1ps
module gpm_sync (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic async_in,
  output logic      level_out
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } gpm_sync_state_t;

  gpm_sync_state_t state_reg;
  gpm_sync_state_t state_next;

  // The first stage feeds only the second, so metastability stays contained.
  always_comb begin
    state_next    = state_reg;
    state_next.s1 = async_in;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    if (state_reg.s2 == state_reg.s3) begin
      state_next.level = state_reg.s3;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign level_out = state_reg.level;

endmodule : gpm_sync

//--- hw/gpm_pin_sel.sv
// Combinational source selector for one general pin.
`timescale 1ns/1ps
module gpm_pin_sel #(
  parameter bit EXTENDED = 1'b0
) (
  input  wire logic [4:0]            sel,
  input  wire gpm_pkg::gpm_src_t     src,
  input  wire gpm_pkg::gpm_derived_t drv,
  input  wire logic                  legacy_level,
  output logic                       level
);

  // Unlisted codes drive the inactive level so a bad write cannot glitch the pin.
  always_comb begin
    level = 1'b0;
    unique case (sel)
      gpm_pkg::CODE_LEGACY: level = legacy_level;
      gpm_pkg::CODE_INT:    level = src.cfg_int;
      gpm_pkg::CODE_SPAN:   level = drv.span;
      gpm_pkg::CODE_LED_A:  level = src.led_a;
      gpm_pkg::CODE_LED_B:  level = src.led_b;
      gpm_pkg::CODE_LED_AB: level = src.led_a | src.led_b;
      gpm_pkg::CODE_DCY_A:  level = src.data_cycle_a;
      gpm_pkg::CODE_DCY_B:  level = src.data_cycle_b;
      gpm_pkg::CODE_DCY_AB: level = src.data_cycle_a | src.data_cycle_b;
      gpm_pkg::CODE_TOGGLE: level = drv.toggle;
      gpm_pkg::CODE_ZERO:   level = 1'b0;
      gpm_pkg::CODE_ONE:    level = EXTENDED;
      gpm_pkg::CODE_OSC:    level = EXTENDED & drv.osc;
      default:              level = 1'b0;
    endcase
  end

endmodule : gpm_pin_sel

//--- hw/gpm_mux.sv
// General-pin function multiplexer with its register port.
`timescale 1ns/1ps
module gpm_mux (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [15:0]       reg_rdata,
  input  wire gpm_pkg::gpm_src_t src,
  input  wire logic              osc_32k,
  output logic                   first_general_pin,
  output logic                   second_general_pin
);

  typedef struct packed {
    logic [4:0]  sel0;
    logic [4:0]  sel1;
    logic        pol;
    logic        span;
    logic        toggle;
    logic        pin0;
    logic        pin1;
    logic [15:0] rdata;
  } gpm_state_t;

  gpm_state_t           state_reg;
  gpm_state_t           state_next;
  gpm_pkg::gpm_derived_t drv;
  logic                 osc_level;
  logic                 level0;
  logic                 level1;

  // Builds the read value of one register; unmapped and reserved bits read zero.
  function automatic logic [15:0] read_word(input logic [7:0] addr, input gpm_state_t st);
    logic [15:0] w;
    w = 16'h0000;
    if (addr == gpm_pkg::ADDR_ALT_CFG) begin
      w[gpm_pkg::SEL0_LSB +: gpm_pkg::SEL_W] = st.sel0;
      w[gpm_pkg::SEL1_LSB +: gpm_pkg::SEL_W] = st.sel1;
    end else if (addr == gpm_pkg::ADDR_PIN_CTRL) begin
      w[gpm_pkg::POL_BIT] = st.pol;
    end
    return w;
  endfunction : read_word

  gpm_sync u_osc_sync (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .async_in  (osc_32k),
    .level_out (osc_level)
  );

  always_comb begin
    drv.span   = state_reg.span;
    drv.toggle = state_reg.toggle;
    drv.osc    = osc_level;
  end

  gpm_pin_sel #(
    .EXTENDED (1'b0)
  ) u_sel0 (
    .sel          (state_reg.sel0),
    .src          (src),
    .drv          (drv),
    .legacy_level (src.legacy_int),
    .level        (level0)
  );

  gpm_pin_sel #(
    .EXTENDED (1'b1)
  ) u_sel1 (
    .sel          (state_reg.sel1),
    .src          (src),
    .drv          (drv),
    .legacy_level (src.legacy_sample_out),
    .level        (level1)
  );

  // Sources are sampled here so a pin lags a direct source by one clock, and span or toggle causes by two.
  always_comb begin
    state_next = state_reg;
    if (reg_wr && reg_addr == gpm_pkg::ADDR_ALT_CFG) begin
      state_next.sel0 = reg_wdata[gpm_pkg::SEL0_LSB +: gpm_pkg::SEL_W];
      state_next.sel1 = reg_wdata[gpm_pkg::SEL1_LSB +: gpm_pkg::SEL_W];
    end
    if (reg_wr && reg_addr == gpm_pkg::ADDR_PIN_CTRL) begin
      state_next.pol = reg_wdata[gpm_pkg::POL_BIT];
    end
    if (reg_rd) begin
      state_next.rdata = read_word(reg_addr, state_reg);
    end
    // A start in the same cycle as an end wins, so a one-slot sample still shows.
    if (src.slot_first_start) begin
      state_next.span = 1'b1;
    end else if (src.slot_last_end) begin
      state_next.span = 1'b0;
    end
    if (src.sample_tick) begin
      state_next.toggle = ~state_reg.toggle;
    end
    state_next.pin0 = level0 ^ state_reg.pol;
    state_next.pin1 = level1;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg      <= '0;
      state_reg.sel0 <= gpm_pkg::SEL_RESET;
      state_reg.sel1 <= gpm_pkg::SEL_RESET;
      state_reg.pol  <= gpm_pkg::POL_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign first_general_pin  = state_reg.pin0;
  assign second_general_pin = state_reg.pin1;
  assign reg_rdata          = state_reg.rdata;

  sel_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == gpm_pkg::ADDR_ALT_CFG) |=>
      (state_reg.sel0 == $past(reg_wdata[4:0]) && state_reg.sel1 == $past(reg_wdata[12:8])))
    else $error("Select fields did not take the written value.");

  sel_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_rd && reg_addr == gpm_pkg::ADDR_ALT_CFG) |=>
      (reg_rdata == {3'h0, $past(state_reg.sel1), 3'h0, $past(state_reg.sel0)}))
    else $error("Select register read back wrong.");

  legacy_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(state_reg.sel0) == gpm_pkg::CODE_LEGACY) |->
      (first_general_pin == ($past(src.legacy_int) ^ $past(state_reg.pol))))
    else $error("First pin does not follow the legacy interrupt.");

  int_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(state_reg.sel0) == gpm_pkg::CODE_INT && !$past(state_reg.pol)) |->
      (first_general_pin == $past(src.cfg_int)))
    else $error("First pin does not follow the configured interrupt.");

  span_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    (src.slot_first_start && state_reg.sel0 == gpm_pkg::CODE_SPAN) ##1
      (state_reg.sel0 == gpm_pkg::CODE_SPAN) |=> (first_general_pin != $past(state_reg.pol)))
    else $error("First pin did not rise at the first timeslot.");

  span_end_a: assert property (@(posedge clk) disable iff (sys_rst)
    (src.slot_last_end && !src.slot_first_start) |=> !state_reg.span)
    else $error("Span level did not clear at the last timeslot.");

  led_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(state_reg.sel0) == gpm_pkg::CODE_LED_AB) |->
      (first_general_pin == (($past(src.led_a) | $past(src.led_b)) ^ $past(state_reg.pol))))
    else $error("First pin does not carry combined pulses.");

  dcy_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(state_reg.sel1) == gpm_pkg::CODE_DCY_A) |-> (second_general_pin == $past(src.data_cycle_a)))
    else $error("Second pin does not flag data cycle A.");

  toggle_tick_a: assert property (@(posedge clk) disable iff (sys_rst)
    src.sample_tick |=> (state_reg.toggle != $past(state_reg.toggle)))
    else $error("Half-rate toggle missed a sample.");

  const_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(state_reg.sel1) == gpm_pkg::CODE_ONE) |-> second_general_pin)
    else $error("Second pin not held high.");

  zero_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(state_reg.sel1) == gpm_pkg::CODE_ZERO) |-> !second_general_pin)
    else $error("Second pin not held low.");

  led_b_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(state_reg.sel0) == gpm_pkg::CODE_LED_B) |->
      (first_general_pin == ($past(src.led_b) ^ $past(state_reg.pol))))
    else $error("First pin does not carry slot B pulses.");

  dcy_first_a: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(state_reg.sel0) == gpm_pkg::CODE_DCY_AB) |->
      (first_general_pin == (($past(src.data_cycle_a) | $past(src.data_cycle_b)) ^ $past(state_reg.pol))))
    else $error("First pin does not flag any data cycle.");

  toggle_first_a: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(state_reg.sel0) == gpm_pkg::CODE_TOGGLE) |->
      (first_general_pin == ($past(state_reg.toggle) ^ $past(state_reg.pol))))
    else $error("First pin does not carry the half-rate toggle.");

  led_second_a: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(state_reg.sel1) == gpm_pkg::CODE_LED_A) |-> (second_general_pin == $past(src.led_a)))
    else $error("Second pin does not carry slot A pulses.");

  dcy_second_a: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(state_reg.sel1) == gpm_pkg::CODE_DCY_AB) |->
      (second_general_pin == ($past(src.data_cycle_a) | $past(src.data_cycle_b))))
    else $error("Second pin does not flag any data cycle.");

  toggle_second_a: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(state_reg.sel1) == gpm_pkg::CODE_TOGGLE) |-> (second_general_pin == $past(state_reg.toggle)))
    else $error("Second pin does not carry the half-rate toggle.");

  osc_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(state_reg.sel1) == gpm_pkg::CODE_OSC) |-> (second_general_pin == $past(osc_level)))
    else $error("Second pin does not follow the oscillator.");

  legacy_second_a: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(state_reg.sel1) == gpm_pkg::CODE_LEGACY) |-> (second_general_pin == $past(src.legacy_sample_out)))
    else $error("Second pin does not follow the legacy sample output.");

  int_second_a: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(state_reg.sel1) == gpm_pkg::CODE_INT) |-> (second_general_pin == $past(src.cfg_int)))
    else $error("Second pin does not follow the configured interrupt.");

  pol_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == gpm_pkg::ADDR_PIN_CTRL) |=> (state_reg.pol == $past(reg_wdata[0])))
    else $error("Polarity did not take the written value.");

  pol_invert_a: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(state_reg.sel0) == gpm_pkg::CODE_ZERO) |-> (first_general_pin == $past(state_reg.pol)))
    else $error("First pin idle level does not follow the polarity.");

  sel_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !(reg_wr && reg_addr == gpm_pkg::ADDR_ALT_CFG) |=> ($stable(state_reg.sel0) && $stable(state_reg.sel1)))
    else $error("Select fields changed without a write.");

endmodule : gpm_mux

//--- tb/gpm_src_model.sv
// Stand-in for the timeslot sequencer and the 32 kHz oscillator feeding the pin multiplexer.
`timescale 1ns/1ps
module gpm_src_model #(
  parameter realtime OSC_HALF = 15625.0
) (
  input  wire logic         clk,
  output gpm_pkg::gpm_src_t src,
  output logic              osc_32k
);
  initial begin
    src     = '0;
    osc_32k = 1'b0;
  end
  // The oscillator runs free and unrelated in phase to clk, as the real one does.
  always #(OSC_HALF) osc_32k = ~osc_32k;
  // Sources change after the falling edge so that the block samples them settled.
  task automatic drive(input gpm_pkg::gpm_src_t v);
    @(negedge clk);
    src = v;
  endtask : drive
endmodule : gpm_src_model

//--- tb/test_gpio_alternate_function_mux.sv
// Self-checking testbench for the general-pin function multiplexer.
`timescale 1ns/1ps
module test_gpio_alternate_function_mux;
  logic              clk;
  logic              sys_rst;
  logic [7:0]        reg_addr;
  logic [15:0]       reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [15:0]       reg_rdata;
  gpm_pkg::gpm_src_t src;
  logic              osc_32k;
  logic              first_general_pin;
  logic              second_general_pin;
  int                num_errors;
  int                cmp_count;
  logic              tog;
  logic              pol;
  logic [4:0]        c1;
  logic [4:0]        codes [11];
  logic [9:0]        pats [3];
  localparam logic [7:0] ALT = gpm_pkg::ADDR_ALT_CFG;
  localparam logic [7:0] CTL = gpm_pkg::ADDR_PIN_CTRL;

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  gpm_mux uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src(src), .osc_32k(osc_32k),
    .first_general_pin(first_general_pin), .second_general_pin(second_general_pin));
  // A short oscillator period keeps the run brief; it stays well above the synchroniser delay.
  gpm_src_model #(.OSC_HALF(103.0)) m (.clk(clk), .src(src), .osc_32k(osc_32k));

  task automatic conclude();
    if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string name);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    chk(name, exp, reg_rdata);
  endtask : rd

  task automatic step(input logic [9:0] v);
    m.drive(v);
    if (v[0]) tog = ~tog;
    @(posedge clk);
    #1;
  endtask : step

  task automatic pins(input logic e0, input logic e1);
    chk("first_general_pin", {15'h0, e0 ^ pol}, {15'h0, first_general_pin});
    chk("second_general_pin", {15'h0, e1}, {15'h0, second_general_pin});
  endtask : pins

  task automatic wait_osc(input logic lvl);
    int n;
    n = 0;
    while (osc_32k !== lvl && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n == 100) begin
      num_errors++;
      $display("[ERR] osc_32k expected %h seen %h", lvl, osc_32k);
      conclude();
    end
  endtask : wait_osc

  function automatic logic lvl(input logic [4:0] c, input logic [9:0] s, input logic second);
    case (c)
      5'h00: return second ? s[7] : s[9];
      5'h01: return s[8];
      5'h05: return s[4];
      5'h06: return s[3];
      5'h07: return s[4] | s[3];
      5'h0c: return s[2];
      5'h0d: return s[1];
      5'h0e: return s[2] | s[1];
      5'h11: return second;
      default: return 1'b0;
    endcase
  endfunction : lvl

  initial begin
    sys_rst    = 1'b1;
    reg_addr   = 8'h00;
    reg_wdata  = 16'h0000;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    num_errors = 0;
    cmp_count  = 0;
    tog        = 1'b0;
    pol        = 1'b0;
    codes = '{5'h00, 5'h01, 5'h05, 5'h06, 5'h07, 5'h0c, 5'h0d, 5'h0e, 5'h10, 5'h11, 5'h03};
    pats  = '{10'h155, 10'h2aa, 10'h000};
    repeat (10) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    rd(ALT, 16'h0000, "alt_cfg reset");
    rd(CTL, 16'h0000, "pin_ctrl reset");
    // Reserved bits are written high, while the second pin still gets a listed code.
    wr(ALT, 16'hf3ef);
    rd(ALT, 16'h130f, "alt_cfg fields");
    wr(CTL, 16'hffff);
    rd(CTL, 16'h0001, "pin_ctrl fields");
    wr(8'h05, 16'h1234);
    rd(8'h05, 16'h0000, "unmapped read");
    rd(ALT, 16'h130f, "alt_cfg kept");
    for (int p = 0; p < 2; p++) begin
      pol = p[0];
      wr(CTL, {15'h0, pol});
      foreach (codes[i]) begin
        // The second pin takes only listed codes, so the unlisted entry sends it the low code.
        c1 = (codes[i] == 5'h03) ? 5'h10 : codes[i];
        wr(ALT, {3'h0, c1, 3'h0, codes[i]});
        foreach (pats[j]) begin
          step(pats[j]);
          pins(lvl(codes[i], pats[j], 1'b0), lvl(c1, pats[j], 1'b1));
        end
      end
    end
    wr(ALT, 16'h0202);
    step(10'h020);
    step(10'h000);
    pins(1'b0, 1'b0);
    step(10'h040);
    step(10'h000);
    pins(1'b1, 1'b1);
    step(10'h000);
    step(10'h000);
    pins(1'b1, 1'b1);
    step(10'h020);
    step(10'h000);
    pins(1'b0, 1'b0);
    wr(ALT, 16'h0f0f);
    repeat (3) begin
      step(10'h001);
      step(10'h000);
      pins(tog, tog);
    end
    // The second pin follows the oscillator only after the synchroniser, so each level is given time to settle.
    wr(ALT, 16'h1313);
    wait_osc(1'b0);
    wait_osc(1'b1);
    repeat (8) @(posedge clk);
    #1;
    pins(1'b0, 1'b1);
    wait_osc(1'b0);
    repeat (8) @(posedge clk);
    #1;
    pins(1'b0, 1'b0);
    // A reset in mid-run must bring both selects and the polarity back to their reset values.
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    pol = 1'b0;
    rd(ALT, 16'h0000, "alt_cfg after reset");
    rd(CTL, 16'h0000, "pin_ctrl after reset");
    step(10'h280);
    pins(1'b1, 1'b1);
    conclude();
  end
endmodule : test_gpio_alternate_function_mux
